// [rtl/usbeb_map.vh]
// Register map, field positions, reset values and timing for the endpoint bank controller
`ifndef USBEB_MAP_VH
`define USBEB_MAP_VH

`define USBEB_A_DEVCTL      12'h000
`define USBEB_A_DEVFLG      12'h004
`define USBEB_A_DEVIEN      12'h008
`define USBEB_A_FRAME       12'h00C
`define USBEB_A_EPCFG       12'h010
`define USBEB_A_EPFLG       12'h014
`define USBEB_A_EPCTL       12'h018
`define USBEB_A_EPIEN       12'h01C
`define USBEB_A_BYCNT       12'h020
`define USBEB_A_DPORT       12'h024

`define USBEB_DC_DETACH     0
`define USBEB_DC_RWK        1
`define USBEB_DC_LOWSPD     2
`define USBEB_DEVCTL_RST    3'h1

`define USBEB_DF_SUSP       0
`define USBEB_DF_SOF        2
`define USBEB_DF_EORST      3
`define USBEB_DF_WAKE       4
`define USBEB_DF_EORSM      5
`define USBEB_DF_UPRSM      6
`define USBEB_DEVIEN_RST    8'h08
`define USBEB_DEV_MASK      8'h7D
`define USBEB_FR_CRCERR     4

`define USBEB_EC_DIRIN      0
`define USBEB_EC_DOUBLE     1
`define USBEB_EC_ISO        2

`define USBEB_EF_INFREE     0
`define USBEB_EF_STALL      1
`define USBEB_EF_OUTRX      2
`define USBEB_EF_SETUP      3
`define USBEB_EF_NAKOUT     4
`define USBEB_EF_UNDER      5
`define USBEB_EF_NAKIN      6
`define USBEB_EF_OVER       7

`define USBEB_CT_CTRL       0
`define USBEB_CT_KILL       1
`define USBEB_CT_RWOK       2

`define USBEB_CLK_MHZ       100
`define USBEB_RWK_IDLE_US   5000
`define USBEB_RWK_DRIVE_US  2000
// Cycle counts of the two microsecond figures above at the clock rate
`define USBEB_RWK_IDLE_CYC  20'h7_A120
`define USBEB_RWK_DRIVE_CYC 20'h3_0D40

`endif

// [rtl/usbeb_bank_ram.v]
// Flip-flop storage shared by the endpoint banks, one write and one read port
module usbeb_bank_ram #(
  parameter AW = 7
) (
  // Clock
  input  wire          clk,
  // Write port
  input  wire          we,
  input  wire [AW-1:0] waddr,
  input  wire [7:0]    wdata,
  // Read port
  input  wire [AW-1:0] raddr,
  output wire [7:0]    rdata
);
  reg [7:0] mem [0:(1<<AW)-1];

  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  assign rdata = mem[raddr];
endmodule

// [rtl/usbeb_top.v]
// Endpoint bank controller with general device flags, APB register slave
//
// Design decisions made here: the register addresses and the APB interface to the registers.
`include "usbeb_map.vh"
module usbeb_top #(
  parameter                BANK_AW       = 6,
  parameter [19:0]         RWK_IDLE_CYC  = `USBEB_RWK_IDLE_CYC,
  parameter [19:0]         RWK_DRIVE_CYC = `USBEB_RWK_DRIVE_CYC
) (
  // Clock and reset
  input  wire              MCLK,
  input  wire              SYS_RST,
  // APB slave
  input  wire              PSEL,
  input  wire              PENABLE,
  input  wire              PWRITE,
  input  wire [11:0]       PADDR,
  input  wire [31:0]       PWDATA,
  output reg  [31:0]       PRDATA,
  output reg               PREADY,
  output reg               PSLVERR,
  // OUT packet from the serial engine
  input  wire              OUT_START,
  input  wire              OUT_BYTE_VALID,
  input  wire [7:0]        OUT_BYTE,
  input  wire              OUT_END,
  input  wire              OUT_CRC_BAD,
  // IN packet to the serial engine
  input  wire              IN_TOKEN,
  output reg               IN_VALID,
  output reg  [7:0]        IN_BYTE,
  output reg               IN_DONE,
  // Handshake and frame events
  input  wire              SETUP_RX,
  input  wire              STALL_SENT,
  input  wire              SOF_RX,
  input  wire              SOF_CRC_BAD,
  // Line state events
  input  wire              SUSPEND_DET,
  input  wire              LINE_NONIDLE,
  input  wire              BUS_RESET_END,
  input  wire              RESUME_END,
  input  wire              HOST_MODE,
  input  wire              USB_CLK_FROZEN,
  // Pads and interrupts
  output reg               PULLUP_DP,
  output reg               PULLUP_DM,
  output reg               RESUME_DRIVE,
  output reg               EP_IRQ,
  output reg               DEV_IRQ
);
  localparam [BANK_AW:0] BANK_FULL = {1'b1, {BANK_AW{1'b0}}};
  localparam [1:0]       RWK_IDLE  = 2'h0;
  localparam [1:0]       RWK_WAIT  = 2'h1;
  localparam [1:0]       RWK_SEND  = 2'h2;

  // Clear-by-writing-zero: bits written 0 are cleared
  function [7:0] zero_clr;
    input       hit;
    input [7:0] wdat;
    begin
      zero_clr = hit ? ~wdat : 8'h00;
    end
  endfunction

  function [31:0] pad_byte;
    input [7:0] b;
    begin
      pad_byte = {24'h00_0000, b};
    end
  endfunction

  reg               detach;
  reg               rwk_req;
  reg               low_speed;
  reg  [7:0]        dev_flags;
  reg  [7:0]        dev_en;
  reg               fn_crc_err;
  reg  [1:0]        rwk_state;
  reg  [19:0]       rwk_cnt;
  reg               ep_dir_in;
  reg               ep_dbl;
  reg               ep_iso;
  reg  [7:0]        ep_flags;
  reg  [7:0]        ep_en;
  reg               ctrl_flag;
  reg  [1:0]        busy;
  reg  [BANK_AW:0]  bcnt [0:1];
  reg               cur;
  reg               usb_bank;
  reg  [BANK_AW:0]  cpu_ptr;
  reg  [BANK_AW:0]  usb_ptr;
  reg               out_act;
  reg               out_ovf;
  reg               in_act;
  integer           i;

  wire              acc    = PSEL & PENABLE & PREADY;
  wire              wr     = acc & PWRITE;
  wire              rd     = acc & ~PWRITE;
  wire              setup  = PSEL & PENABLE & ~PREADY;
  wire [BANK_AW:0]  cnt_cur = bcnt[cur];
  wire [BANK_AW:0]  cnt_usb = bcnt[usb_bank];
  wire [7:0]        ram_rdata;

  wire rw_allowed = ep_dir_in ? (~busy[cur] & (cnt_cur < BANK_FULL))
                              : (busy[cur] & (cpu_ptr < cnt_cur));
  wire [BANK_AW:0] byte_count = ep_dir_in ? cnt_cur : cnt_cur - cpu_ptr;

  wire wr_epctl = wr & (PADDR == `USBEB_A_EPCTL);
  wire cfg_wr   = wr & (PADDR == `USBEB_A_EPCFG);
  wire fw_rel   = wr_epctl & ~PWDATA[`USBEB_CT_CTRL] & ctrl_flag;
  wire dport_rd = rd & (PADDR == `USBEB_A_DPORT) & ~ep_dir_in & rw_allowed;
  wire dport_wr = wr & (PADDR == `USBEB_A_DPORT) & ep_dir_in & rw_allowed;

  // last written bank, never the one being sent
  wire last_bk  = ep_dbl ? ~cur : cur;
  wire kill     = wr_epctl & PWDATA[`USBEB_CT_KILL] & ep_dir_in & busy[last_bk]
                  & ~(in_act & (usb_bank == last_bk));

  wire out_ok   = OUT_START & ~ep_dir_in & ~busy[usb_bank] & ~out_act;
  wire out_done = OUT_END & out_act;
  wire in_start = IN_TOKEN & ep_dir_in & ~in_act & busy[usb_bank];
  wire in_empty = IN_TOKEN & ep_dir_in & ~in_act & ~busy[usb_bank];
  wire in_fin   = in_act & (usb_ptr >= cnt_usb);

  reg  [1:0] busy_set;
  reg  [1:0] busy_clr;
  reg  [1:0] next_busy;
  reg        next_cur;
  always @* begin
    busy_set = 2'b00;
    busy_clr = 2'b00;
    if (out_done) begin
      busy_set[usb_bank] = 1'b1;
    end
    if (fw_rel) begin
      busy_set[cur] = ep_dir_in;
      busy_clr[cur] = ~ep_dir_in;
    end
    if (in_fin) begin
      busy_clr[usb_bank] = 1'b1;
    end
    if (kill) begin
      busy_clr[last_bk] = 1'b1;
    end
    next_busy = cfg_wr ? 2'b00 : ((busy | busy_set) & ~busy_clr);
    next_cur  = (fw_rel & ep_dbl) ? ~cur : cur;
  end

  wire evt_out = ~ep_dir_in & ~cfg_wr & next_busy[next_cur] & (fw_rel | ~busy[cur]);
  wire evt_in  = (ep_dir_in & ~cfg_wr & ~next_busy[next_cur] & (fw_rel | busy[cur]))
                 | (cfg_wr & PWDATA[`USBEB_EC_DIRIN]);

  reg [7:0] ep_set;
  always @* begin
    ep_set = 8'h00;
    ep_set[`USBEB_EF_INFREE] = evt_in;
    ep_set[`USBEB_EF_OUTRX]  = evt_out;
    ep_set[`USBEB_EF_SETUP]  = SETUP_RX;
    ep_set[`USBEB_EF_STALL]  = STALL_SENT | (out_done & ep_iso & OUT_CRC_BAD);
    // drop or refuse OUT into full banks
    ep_set[`USBEB_EF_NAKOUT] = OUT_START & ~ep_dir_in & ~out_ok & ~ep_iso;
    ep_set[`USBEB_EF_UNDER]  = in_empty & ep_iso;
    ep_set[`USBEB_EF_NAKIN]  = in_empty & ~ep_iso;
    ep_set[`USBEB_EF_OVER]   = out_done & (out_ovf | (OUT_BYTE_VALID & usb_ptr >= BANK_FULL));
  end
  wire [7:0] ep_clr = zero_clr(wr & (PADDR == `USBEB_A_EPFLG), PWDATA[7:0]);

  // Resume signalling sequence
  wire rwk_ok    = wr & (PADDR == `USBEB_A_DEVCTL) & PWDATA[`USBEB_DC_RWK]
                   & dev_flags[`USBEB_DF_SUSP] & (rwk_state == RWK_IDLE);
  wire rwk_begin = (rwk_state == RWK_WAIT) & (rwk_cnt == RWK_IDLE_CYC - 20'h0_0001);

  reg [7:0] dev_set;
  reg [7:0] dev_clr;
  always @* begin
    dev_set = 8'h00;
    dev_set[`USBEB_DF_SUSP]  = SUSPEND_DET;
    dev_set[`USBEB_DF_SOF]   = SOF_RX;
    dev_set[`USBEB_DF_EORST] = BUS_RESET_END;
    // own resume does not count as activity
    dev_set[`USBEB_DF_WAKE]  = LINE_NONIDLE & ~RESUME_DRIVE;
    dev_set[`USBEB_DF_EORSM] = RESUME_END;
    dev_set[`USBEB_DF_UPRSM] = rwk_begin;
    dev_clr = zero_clr(wr & (PADDR == `USBEB_A_DEVFLG), PWDATA[7:0]);
    if (USB_CLK_FROZEN) begin
      dev_clr[`USBEB_DF_WAKE]  = 1'b0;
      dev_clr[`USBEB_DF_UPRSM] = 1'b0;
    end
    // Suspend and wake exclude each other; resume start ends suspend
    dev_clr[`USBEB_DF_SUSP] = dev_clr[`USBEB_DF_SUSP] | dev_set[`USBEB_DF_WAKE] | rwk_begin;
    dev_clr[`USBEB_DF_WAKE] = dev_clr[`USBEB_DF_WAKE] | SUSPEND_DET;
  end

  reg [31:0] rd_mux;
  reg        rd_hit;
  always @* begin
    rd_hit = 1'b1;
    case (PADDR)
      `USBEB_A_DEVCTL: rd_mux = {29'h0000_0000, low_speed, rwk_req, detach};
      `USBEB_A_DEVFLG: rd_mux = pad_byte(dev_flags);
      `USBEB_A_DEVIEN: rd_mux = pad_byte(dev_en);
      `USBEB_A_FRAME:  rd_mux = pad_byte({3'h0, fn_crc_err, 4'h0});
      `USBEB_A_EPCFG:  rd_mux = {29'h0000_0000, ep_iso, ep_dbl, ep_dir_in};
      `USBEB_A_EPFLG:  rd_mux = pad_byte(ep_flags);
      `USBEB_A_EPCTL:  rd_mux = {29'h0000_0000, rw_allowed, 1'b0, ctrl_flag};
      `USBEB_A_EPIEN:  rd_mux = pad_byte(ep_en);
      `USBEB_A_BYCNT:  rd_mux = {{(31-BANK_AW){1'b0}}, byte_count};
      `USBEB_A_DPORT:  rd_mux = pad_byte((ep_dir_in | ~rw_allowed) ? 8'h00 : ram_rdata);
      default: begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  // One wait state: answer is prepared while PREADY is low
  always @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= setup;
      PSLVERR <= setup & ~rd_hit;
      if (setup) begin
        PRDATA <= PWRITE ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  // Device control and flags
  always @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      {low_speed, rwk_req, detach} <= `USBEB_DEVCTL_RST;
      dev_flags    <= 8'h00;
      dev_en       <= `USBEB_DEVIEN_RST;
      fn_crc_err   <= 1'b0;
      rwk_state    <= RWK_IDLE;
      rwk_cnt      <= 20'h0_0000;
      RESUME_DRIVE <= 1'b0;
      PULLUP_DP    <= 1'b0;
      PULLUP_DM    <= 1'b0;
      DEV_IRQ      <= 1'b0;
    end else begin
      if (wr & (PADDR == `USBEB_A_DEVCTL)) begin
        detach    <= PWDATA[`USBEB_DC_DETACH];
        low_speed <= PWDATA[`USBEB_DC_LOWSPD];
      end
      if (wr & (PADDR == `USBEB_A_DEVIEN)) begin
        dev_en <= PWDATA[7:0] & `USBEB_DEV_MASK;
      end
      dev_flags <= ((dev_flags & ~dev_clr) | dev_set) & `USBEB_DEV_MASK;
      // error marked with the frame flag
      if (SOF_RX) begin
        fn_crc_err <= SOF_CRC_BAD;
      end
      case (rwk_state)
        RWK_IDLE: begin
          if (rwk_ok) begin
            rwk_req   <= 1'b1;
            rwk_state <= RWK_WAIT;
            rwk_cnt   <= 20'h0_0000;
          end
        end
        RWK_WAIT: begin
          if (rwk_begin) begin
            rwk_state    <= RWK_SEND;
            rwk_cnt      <= 20'h0_0000;
            RESUME_DRIVE <= 1'b1;
          end else if (LINE_NONIDLE) begin
            rwk_cnt <= 20'h0_0000;
          end else begin
            rwk_cnt <= rwk_cnt + 20'h0_0001;
          end
        end
        RWK_SEND: begin
          if (rwk_cnt == RWK_DRIVE_CYC - 20'h0_0001) begin
            rwk_state    <= RWK_IDLE;
            rwk_req      <= 1'b0;
            RESUME_DRIVE <= 1'b0;
          end else begin
            rwk_cnt <= rwk_cnt + 20'h0_0001;
          end
        end
        default: rwk_state <= RWK_IDLE;
      endcase
      PULLUP_DP <= ~detach & ~low_speed & ~HOST_MODE;
      PULLUP_DM <= ~detach & low_speed & ~HOST_MODE;
      DEV_IRQ   <= |(dev_flags & dev_en);
    end
  end

  // Endpoint banks
  always @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ep_dir_in <= 1'b0;
      ep_dbl    <= 1'b0;
      ep_iso    <= 1'b0;
      ep_flags  <= 8'h00;
      ep_en     <= 8'h00;
      ctrl_flag <= 1'b0;
      busy      <= 2'b00;
      for (i = 0; i < 2; i = i + 1) begin
        bcnt[i] <= {(BANK_AW+1){1'b0}};
      end
      cur       <= 1'b0;
      usb_bank  <= 1'b0;
      cpu_ptr   <= {(BANK_AW+1){1'b0}};
      usb_ptr   <= {(BANK_AW+1){1'b0}};
      out_act   <= 1'b0;
      out_ovf   <= 1'b0;
      in_act    <= 1'b0;
      IN_VALID  <= 1'b0;
      IN_BYTE   <= 8'h00;
      IN_DONE   <= 1'b0;
      EP_IRQ    <= 1'b0;
    end else begin
      IN_VALID <= 1'b0;
      IN_DONE  <= 1'b0;
      if (wr & (PADDR == `USBEB_A_EPIEN)) begin
        ep_en <= PWDATA[7:0];
      end
      // Set wins over a same-cycle software clear
      ep_flags  <= (ep_flags & ~ep_clr) | ep_set;
      ctrl_flag <= (ctrl_flag & ~(fw_rel | cfg_wr)) | evt_out | evt_in;
      busy      <= next_busy;
      cur       <= next_cur;
      EP_IRQ    <= |(ep_flags & ep_en);
      if (cfg_wr) begin
        // Reconfiguring empties every bank
        ep_dir_in <= PWDATA[`USBEB_EC_DIRIN];
        ep_dbl    <= PWDATA[`USBEB_EC_DOUBLE];
        ep_iso    <= PWDATA[`USBEB_EC_ISO];
        cur       <= 1'b0;
        usb_bank  <= 1'b0;
        cpu_ptr   <= {(BANK_AW+1){1'b0}};
        out_act   <= 1'b0;
        in_act    <= 1'b0;
        for (i = 0; i < 2; i = i + 1) begin
          bcnt[i] <= {(BANK_AW+1){1'b0}};
        end
      end else begin
        if (dport_rd) begin
          cpu_ptr <= cpu_ptr + 1'b1;
        end
        if (dport_wr) begin
          bcnt[cur] <= cnt_cur + 1'b1;
        end
        if (fw_rel & ~ep_dir_in) begin
          cpu_ptr   <= {(BANK_AW+1){1'b0}};
          bcnt[cur] <= {(BANK_AW+1){1'b0}};
        end
        if (out_ok) begin
          out_act <= 1'b1;
          out_ovf <= 1'b0;
          usb_ptr <= {(BANK_AW+1){1'b0}};
        end
        if (out_act & OUT_BYTE_VALID) begin
          if (usb_ptr < BANK_FULL) begin
            usb_ptr <= usb_ptr + 1'b1;
          end else begin
            out_ovf <= 1'b1;
          end
        end
        if (out_done) begin
          out_act        <= 1'b0;
          bcnt[usb_bank] <= usb_ptr;
          usb_bank       <= ep_dbl ? ~usb_bank : usb_bank;
        end
        if (in_start) begin
          in_act  <= 1'b1;
          usb_ptr <= {(BANK_AW+1){1'b0}};
        end
        if (in_act) begin
          if (in_fin) begin
            in_act         <= 1'b0;
            IN_DONE        <= 1'b1;
            bcnt[usb_bank] <= {(BANK_AW+1){1'b0}};
            usb_bank       <= ep_dbl ? ~usb_bank : usb_bank;
          end else begin
            IN_VALID <= 1'b1;
            IN_BYTE  <= ram_rdata;
            usb_ptr  <= usb_ptr + 1'b1;
          end
        end
        if (kill) begin
          bcnt[last_bk] <= {(BANK_AW+1){1'b0}};
          if (ep_dbl) begin
            usb_bank <= cur;
          end
        end
      end
    end
  end

  // Only one direction writes the store at a time
  wire              ram_we    = ep_dir_in ? dport_wr
                                          : (out_act & OUT_BYTE_VALID & (usb_ptr < BANK_FULL));
  wire [BANK_AW:0]  ram_waddr = ep_dir_in ? {cur, cnt_cur[BANK_AW-1:0]}
                                          : {usb_bank, usb_ptr[BANK_AW-1:0]};
  wire [7:0]        ram_wdata = ep_dir_in ? PWDATA[7:0] : OUT_BYTE;
  wire [BANK_AW:0]  ram_raddr = ep_dir_in ? {usb_bank, usb_ptr[BANK_AW-1:0]}
                                          : {cur, cpu_ptr[BANK_AW-1:0]};

  usbeb_bank_ram #(
    .AW    (BANK_AW + 1)
  ) u_ram (
    .clk   (MCLK),
    .we    (ram_we),
    .waddr (ram_waddr),
    .wdata (ram_wdata),
    .raddr (ram_raddr),
    .rdata (ram_rdata)
  );
endmodule

// [tb/usbeb_top_properties.sv]
// Port-level assertions for the endpoint bank controller
`include "usbeb_map.vh"
module usbeb_top_properties #(
  parameter [19:0] RWK_DRIVE_CYC = 20'h0_0004
) (
  // Clock, reset and APB
  input wire        MCLK,
  input wire        SYS_RST,
  input wire        PSEL,
  input wire        PENABLE,
  input wire        PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PWDATA,
  input wire        PREADY,
  // Link and pads
  input wire        HOST_MODE,
  input wire        IN_VALID,
  input wire        IN_DONE,
  input wire        PULLUP_DP,
  input wire        PULLUP_DM,
  input wire        RESUME_DRIVE
);
  timeunit 1ns;
  timeprecision 1ns;
  reg  [19:0] drv_cnt;
  wire        ctl_wr;
  assign ctl_wr = PSEL && PENABLE && PREADY && PWRITE && !HOST_MODE
                  && PADDR == `USBEB_A_DEVCTL;
  // Length of the current resume drive
  always @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST)
      drv_cnt <= 20'h0_0000;
    else
      drv_cnt <= RESUME_DRIVE ? drv_cnt + 20'h0_0001 : 20'h0_0000;
  end
  default clocking dc @(posedge MCLK);
  endclocking
  default disable iff (SYS_RST);
  AST_DETACH_OFF:
    assert property (ctl_wr && PWDATA[0] |-> ##[1:3] !PULLUP_DP && !PULLUP_DM)
    else $error("pull-up left on after detach");
  AST_FULL_SPEED:
    assert property (ctl_wr && !PWDATA[0] && !PWDATA[2] |-> ##[1:3] PULLUP_DP && !PULLUP_DM)
    else $error("full speed pull-up wrong");
  AST_LOW_SPEED:
    assert property (ctl_wr && !PWDATA[0] && PWDATA[2] |-> ##[1:3] PULLUP_DM && !PULLUP_DP)
    else $error("low speed pull-up wrong");
  AST_ONE_PULLUP:
    assert property (!(PULLUP_DP && PULLUP_DM))
    else $error("both pull-ups on");
  AST_RESUME_BOUND:
    assert property (RESUME_DRIVE |-> drv_cnt <= RWK_DRIVE_CYC)
    else $error("resume drive too long");
  AST_RESUME_FULL:
    assert property ($fell(RESUME_DRIVE) |-> drv_cnt >= RWK_DRIVE_CYC - 20'h0_0001)
    else $error("resume drive cut short");
  AST_IN_STREAM:
    assert property (IN_VALID |=> IN_VALID || IN_DONE)
    else $error("gap inside IN packet");
  AST_DONE_PULSE:
    assert property (IN_DONE |=> !IN_DONE && !IN_VALID)
    else $error("IN done not a single pulse");
  AST_READY_TIMING:
    assert property ($rose(PSEL && PENABLE) |=> PREADY)
    else $error("APB answer late");
endmodule
bind usbeb_top usbeb_top_properties #(.RWK_DRIVE_CYC(RWK_DRIVE_CYC)) i_usbeb_top_properties (
  .MCLK(MCLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .HOST_MODE(HOST_MODE),
  .IN_VALID(IN_VALID), .IN_DONE(IN_DONE), .PULLUP_DP(PULLUP_DP), .PULLUP_DM(PULLUP_DM),
  .RESUME_DRIVE(RESUME_DRIVE));

// [tb/usbeb_host.sv]
// Host-side packet model: OUT packets with gaps, IN tokens with capture
module usbeb_host (
  // Clock
  input  wire logic       clk,
  // OUT packet
  output logic            out_start = 1'b0,
  output logic            out_bv = 1'b0,
  output logic [7:0]      out_byte = 8'h5A,
  output logic            out_end = 1'b0,
  output logic            out_crc_bad = 1'b0,
  // IN packet
  output logic            in_token = 1'b0,
  input  wire logic       in_valid,
  input  wire logic [7:0] in_byte,
  input  wire logic       in_done
);
  timeunit 1ns;
  timeprecision 1ns;
  // oversize, bad CRC
  // Idle data line shows the inverse of the last byte, never a stale value
  task automatic send(input logic [7:0] b[$], input logic bad);
    out_start <= 1'b1;
    @(posedge clk) out_start <= 1'b0;
    foreach (b[i]) begin
      repeat ($urandom_range(2, 1)) @(posedge clk);
      out_bv <= 1'b1;
      out_byte <= b[i];
      @(posedge clk) out_bv <= 1'b0;
      out_byte <= ~b[i];
    end
    @(posedge clk) out_end <= 1'b1;
    out_crc_bad <= bad;
    @(posedge clk) out_end <= 1'b0;
    out_crc_bad <= ~bad;
    @(posedge clk);
  endtask
  task automatic fetch(output logic [7:0] got[$]);
    int k;
    got = {};
    in_token <= 1'b1;
    @(posedge clk) in_token <= 1'b0;
    for (k = 0; k < 100 && in_done !== 1'b1; k++) begin
      @(posedge clk);
      if (in_valid === 1'b1) got.push_back(in_byte);
    end
    @(posedge clk);
  endtask
endmodule

// [tb/test_usb_device_endpoint_bank_ctrl.sv]
// Self-checking bench for the endpoint bank controller
`include "usbeb_map.vh"
`define CHK(n, e, g) checks_done++; \
  if ((g) !== (e)) begin fails++; $display("ERROR %s exp %h got %h", n, e, g); end
module test_usb_device_endpoint_bank_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  logic        MCLK = 0, SYS_RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, sof_bad = 0, er;
  logic [11:0] PADDR = 0, a;
  logic [31:0] PWDATA = 0, rd;
  logic [6:0]  ev = 0;
  logic        hm = 0, frz = 0;
  logic [7:0]  q[$], g[$];
  logic [2:0]  fb[7] = '{3'h2, 3'h0, 3'h3, 3'h5, 3'h4, 3'h3, 3'h1};
  wire  [31:0] PRDATA;
  wire  [7:0]  IN_BYTE, ob;
  wire         PREADY, PSLVERR, IN_VALID, IN_DONE, PULLUP_DP, PULLUP_DM, RESUME_DRIVE;
  wire         EP_IRQ, DEV_IRQ, os, obv, oe, ocrc, tok;
  int          fails = 0, checks_done = 0, cyc = 0, n, lenq[2];
  always #5 MCLK = ~MCLK;
  usbeb_top #(.RWK_IDLE_CYC(20'h0_0008), .RWK_DRIVE_CYC(20'h0_0004)) i_usbeb_top (
    .MCLK(MCLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .OUT_START(os), .OUT_BYTE_VALID(obv), .OUT_BYTE(ob), .OUT_END(oe), .OUT_CRC_BAD(ocrc),
    .IN_TOKEN(tok), .IN_VALID(IN_VALID), .IN_BYTE(IN_BYTE), .IN_DONE(IN_DONE),
    .SETUP_RX(ev[5]), .STALL_SENT(ev[6]), .SOF_RX(ev[0]), .SOF_CRC_BAD(sof_bad),
    .SUSPEND_DET(ev[1]), .LINE_NONIDLE(ev[4]), .BUS_RESET_END(ev[2]), .RESUME_END(ev[3]),
    .HOST_MODE(hm), .USB_CLK_FROZEN(frz), .PULLUP_DP(PULLUP_DP), .PULLUP_DM(PULLUP_DM),
    .RESUME_DRIVE(RESUME_DRIVE), .EP_IRQ(EP_IRQ), .DEV_IRQ(DEV_IRQ));
  usbeb_host i_usbeb_host (.clk(MCLK), .out_start(os), .out_bv(obv), .out_byte(ob),
    .out_end(oe), .out_crc_bad(ocrc), .in_token(tok), .in_valid(IN_VALID),
    .in_byte(IN_BYTE), .in_done(IN_DONE));
  task report_and_stop;
    if (fails == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Called just after an edge; returns just after the edge following completion
  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
    PSEL <= 1;
    PENABLE <= 0;
    PWRITE <= wr;
    PADDR <= ad;
    PWDATA <= d;
    @(posedge MCLK) PENABLE <= 1;
    // Only the bench timeout ends a hung access
    do begin @(posedge MCLK); end while (PREADY !== 1'b1);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 0;
    PENABLE <= 0;
    @(posedge MCLK);
  endtask
  task automatic chk(input logic [11:0] ad, input logic [7:0] m, input logic [7:0] e);
    apb(0, ad, 0);
    `CHK("register", e, rd[7:0] & m)
  endtask
  task automatic mk(input int k);
    g = {};
    repeat (k) g.push_back(8'($urandom));
  endtask
  task automatic rdbank(input int k);
    logic [7:0] x;
    repeat (k) begin
      x = q.pop_front();
      apb(0, `USBEB_A_DPORT, 0);
      `CHK("out byte", {24'h00_0000, x}, rd)
    end
  endtask
  task automatic pulse(input int k);
    ev <= 7'h01 << k;
    sof_bad <= (k == 0);
    @(posedge MCLK) ev <= 0;
    sof_bad <= 0;
    repeat (3) @(posedge MCLK);
  endtask
  always @(posedge MCLK) begin
    cyc++;
    if (cyc == 60000) begin
      fails++;
      report_and_stop;
    end
  end
  initial begin
    void'($urandom(32'h9879));
    repeat (16) @(posedge MCLK);
    SYS_RST <= 0;
    @(posedge MCLK);
    chk(`USBEB_A_DEVCTL, 8'hFF, 8'h01);
    chk(`USBEB_A_DEVIEN, 8'hFF, 8'h08);
    apb(0, 12'h0FC, 0);
    `CHK("unmapped", 1'b1, er)
    for (int ls = 0; ls < 2; ls++) begin
      apb(1, `USBEB_A_DEVCTL, ls << 2);
      repeat (2) @(posedge MCLK);
      `CHK("pull-ups", {ls == 0, ls == 1}, {PULLUP_DP, PULLUP_DM})
      apb(1, `USBEB_A_DEVCTL, 1);
      repeat (2) @(posedge MCLK);
      `CHK("detached", 2'b00, {PULLUP_DP, PULLUP_DM})
    end
    // Each event flag: set, one ignored, zero clears
    for (int k = 0; k < 7; k++) begin
      a = k < 5 ? `USBEB_A_DEVFLG : `USBEB_A_EPFLG;
      pulse(k);
      chk(a, 8'h01 << fb[k], 8'h01 << fb[k]);
      if (k < 5) begin
        `CHK("dev irq", k == 2, DEV_IRQ)
      end
      apb(1, a, 8'hFF);
      chk(a, 8'h01 << fb[k], 8'h01 << fb[k]);
      apb(1, a, 8'hFF ^ (8'h01 << fb[k]));
      chk(a, 8'h01 << fb[k], 8'h00);
    end
    chk(`USBEB_A_FRAME, 8'h10, 8'h10);
    // Host mode drops both pull-ups; frozen clock blocks the wake clear
    apb(1, `USBEB_A_DEVCTL, 0);
    hm <= 1;
    repeat (3) @(posedge MCLK);
    `CHK("host mode", 2'b00, {PULLUP_DP, PULLUP_DM})
    hm <= 0;
    frz <= 1;
    pulse(4);
    apb(1, `USBEB_A_DEVFLG, 8'hEF);
    chk(`USBEB_A_DEVFLG, 8'h10, 8'h10);
    frz <= 0;
    apb(1, `USBEB_A_DEVFLG, 8'hEF);
    chk(`USBEB_A_DEVFLG, 8'h10, 8'h00);
    apb(1, `USBEB_A_DEVCTL, 8'h03);
    chk(`USBEB_A_DEVCTL, 8'h02, 8'h00);
    pulse(1);
    apb(1, `USBEB_A_DEVCTL, 8'h03);
    n = 0;
    while (RESUME_DRIVE !== 1'b1 && n < 200) begin @(posedge MCLK); n++; end
    `CHK("resume drive", 1'b1, RESUME_DRIVE)
    repeat (20) @(posedge MCLK);
    chk(`USBEB_A_DEVCTL, 8'h02, 8'h00);
    chk(`USBEB_A_DEVFLG, 8'h51, 8'h40);
    // Two OUT banks filled before firmware reads either
    apb(1, `USBEB_A_EPCFG, 8'h02);
    apb(1, `USBEB_A_EPIEN, 8'h04);
    for (int p = 0; p < 2; p++) begin
      lenq[p] = $urandom_range(64, 1);
      mk(lenq[p]);
      q = {q, g};
      i_usbeb_host.send(g, 1'b0);
    end
    repeat (3) @(posedge MCLK);
    `CHK("ep irq", 1'b1, EP_IRQ)
    for (int p = 0; p < 2; p++) begin
      chk(`USBEB_A_EPFLG, 8'h04, 8'h04);
      chk(`USBEB_A_EPCTL, 8'h05, 8'h05);
      chk(`USBEB_A_BYCNT, 8'hFF, 8'(lenq[p]));
      apb(1, `USBEB_A_EPFLG, 8'hFB);
      rdbank(lenq[p]);
      chk(`USBEB_A_EPCTL, 8'h04, 8'h00);
      apb(1, `USBEB_A_EPCTL, 0);
    end
    apb(1, `USBEB_A_EPCFG, 0);
    mk(70);
    q = g[0:63];
    i_usbeb_host.send(g, 1'b0);
    chk(`USBEB_A_EPFLG, 8'h84, 8'h84);
    chk(`USBEB_A_BYCNT, 8'hFF, 8'h40);
    rdbank(64);
    apb(1, `USBEB_A_EPCFG, 8'h04);
    mk(8);
    i_usbeb_host.send(g, 1'b1);
    chk(`USBEB_A_EPFLG, 8'h16, 8'h06);
    mk(5);
    i_usbeb_host.send(g, 1'b0);
    chk(`USBEB_A_EPFLG, 8'h10, 8'h00);
    chk(`USBEB_A_BYCNT, 8'hFF, 8'h08);
    // IN bank written, sent, then a killed bank
    apb(1, `USBEB_A_EPCFG, 8'h01);
    apb(1, `USBEB_A_EPIEN, 8'h01);
    chk(`USBEB_A_EPFLG, 8'h01, 8'h01);
    `CHK("ep irq", 1'b1, EP_IRQ)
    apb(1, `USBEB_A_EPFLG, 8'hFE);
    n = $urandom_range(64, 1);
    mk(n);
    q = g;
    foreach (q[i]) apb(1, `USBEB_A_DPORT, q[i]);
    chk(`USBEB_A_BYCNT, 8'hFF, 8'(n));
    apb(1, `USBEB_A_EPCTL, 0);
    i_usbeb_host.fetch(g);
    `CHK("in length", n, g.size())
    foreach (q[i]) begin
      `CHK("in byte", q[i], g[i])
    end
    chk(`USBEB_A_EPFLG, 8'h01, 8'h01);
    apb(1, `USBEB_A_EPFLG, 8'hFE);
    repeat (64) apb(1, `USBEB_A_DPORT, 8'($urandom));
    chk(`USBEB_A_EPCTL, 8'h04, 8'h00);
    apb(1, `USBEB_A_EPCTL, 0);
    apb(1, `USBEB_A_EPCTL, 8'h02);
    i_usbeb_host.fetch(g);
    `CHK("killed length", 0, g.size())
    chk(`USBEB_A_EPFLG, 8'h40, 8'h40);
    apb(1, `USBEB_A_EPCFG, 8'h05);
    i_usbeb_host.fetch(g);
    chk(`USBEB_A_EPFLG, 8'h20, 8'h20);
    report_and_stop;
  end
endmodule
